/* src/burst_trigger_params.svh */
// Offsets, fields and reset values of the burst trigger block
//
// Summary of operation
// - Primary reset, repetition, compare events start burst
// - Slave reset, repetition, compare0/1 enables, bits 7-26
// - Bit 27: slave0 period after event 6
// - Bit 28: slave3 period after event 7
// - Software start bit self-clears one cycle after the write, taken or not
// - Software start ignored while burst disabled
// - 16-bit compare value sets IDLE length
// - Compare and reload have shadow preload copies
// - 16-bit reload value sets burst period
// - Sensitivity: level, rising, falling, both edges
// - Level polarity: 0 high active, 1 low
// - Two-bit source field picks one of four
// - Ten events in two registers, 6-bit slots
// - Triggers taken only when enabled; clearing terminates
// - Single pulse stops at reload; continuous rolls
// - Bits 29-31: event 6, event 7, internal
`ifndef BURST_TRIGGER_PARAMS_SVH
`define BURST_TRIGGER_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define BT_OFF_CTL      8'h20
`define BT_OFF_START    8'h24
`define BT_OFF_CMP      8'h28
`define BT_OFF_RELOAD   8'h2C
`define BT_OFF_EVLO     8'h30
`define BT_OFF_EVHI     8'h34

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define BT_RST_WORD     32'h0000_0000
`define BT_CTL_MASK     32'h0000_07FF
`define BT_EV_MASK      32'h1F7D_F7DF
`define BT_VAL_MASK     32'h0000_FFFF

// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define BT_CTL_EN       0
`define BT_CTL_CONT     1
`define BT_CTL_CLKS_LO  2
`define BT_CTL_PSC_LO   6
`define BT_CTL_SHADOW   10
`define BT_CTL_FLAG     31

// ---------------------------------------------------------------
// Start trigger and event slot layout
// ---------------------------------------------------------------
`define BT_ST_SW        0
`define BT_ST_SEC_BASE  7
`define BT_ST_SEC0_EV6  27
`define BT_ST_SEC3_EV7  28
`define BT_ST_EV6       29
`define BT_ST_EV7       30
`define BT_ST_INT       31
`define BT_SLOT_W       6
`define BT_SLOT_POL     2
`define BT_SLOT_SENS_LO 3
`define BT_CLKS_PRESC   4'hA
`define BT_CLKS_INT0    4'h6

`endif

/* src/burst_trigger_pkg.sv */
// Types shared by the burst trigger block
package burst_trigger_pkg;

  typedef enum logic [1:0] {
    SENS_LEVEL = 2'h0,
    SENS_RISE  = 2'h1,
    SENS_FALL  = 2'h2,
    SENS_BOTH  = 2'h3
  } sens_mode_t;

  typedef enum logic [1:0] {
    BURST_OFF,
    BURST_IDLE,
    BURST_RUN
  } burst_state_t;

endpackage : burst_trigger_pkg

/* src/burst_trigger_and_ext_event_cfg.sv */
// Burst start trigger selection, burst counter and event conditioning
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "burst_trigger_params.svh"

module burst_trigger_and_ext_event_cfg #(
  parameter int CNT_W = 16
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic      [31:0]        regRdata,
  input  wire logic               primaryReset,
  input  wire logic               primaryRepetition,
  input  wire logic [3:0]         primaryCompare,
  input  wire logic [4:0]         secReset,
  input  wire logic [4:0]         secRepetition,
  input  wire logic [4:0]         secCompare0,
  input  wire logic [4:0]         secCompare1,
  input  wire logic [4:0]         secPeriod,
  input  wire logic               basicTimerTriggerOut,
  input  wire logic [3:0]         burstClockIn,
  input  wire logic [39:0]        extSourceIn,
  output logic      [9:0]         extEventActive,
  output logic                    burstStart,
  output logic                    burstRunning,
  output logic                    burstIdle,
  output logic      [CNT_W-1:0]   burstCount
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]                    ctl_r;
  logic [31:0]                    startSel_r;
  logic [CNT_W-1:0]               cmpPre_r;
  logic [CNT_W-1:0]               reloadPre_r;
  logic [CNT_W-1:0]               cmpAct_r;
  logic [CNT_W-1:0]               reloadAct_r;
  logic [31:0]                    evLo_r;
  logic [31:0]                    evHi_r;
  logic [39:0]                    syncA_r;
  logic [39:0]                    syncB_r;
  logic [9:0]                     selPrev_r;
  logic                           armEv6_r;
  logic                           armEv7_r;
  logic [14:0]                    presc_r;
  burst_trigger_pkg::burst_state_t state_r;
  logic [CNT_W-1:0]               count_r;

  logic [59:0]                    evCfg;
  logic [9:0]                     selLevel;
  logic [9:0]                     evNow;
  logic [31:0]                    trigEvents;
  logic                           enable;
  logic                           anyTrigger;
  logic                           takeStart;
  logic                           tick;
  logic                           stopWrite;
  logic                           wrCtl;
  logic                           wrStart;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [14:0] prescMask(input logic [3:0] psc);
    logic [15:0] m;
    m = (16'h0001 << psc) - 16'h0001;
    prescMask = m[14:0];
  endfunction : prescMask

  assign enable    = ctl_r[`BT_CTL_EN];
  assign wrCtl     = regWrite && hit(regAddr, `BT_OFF_CTL);
  assign wrStart   = regWrite && hit(regAddr, `BT_OFF_START);
  assign stopWrite = wrCtl && (!regWdata[`BT_CTL_EN]
                     || !regWdata[`BT_CTL_FLAG]);
  assign evCfg     = {evHi_r[29:0], evLo_r[29:0]};

  // ---------------------------------------------------------------
  // External event conditioning
  // ---------------------------------------------------------------
  // Sources arrive from pins, so every one is synchronised first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 40'h00_0000_0000;
      syncB_r <= 40'h00_0000_0000;
    end else begin
      syncA_r <= extSourceIn;
      syncB_r <= syncA_r;
    end
  end

  genvar e;
  generate
    for (e = 0; e < 10; e++) begin : g_event
      logic [5:0] slot;
      logic [1:0] sens;
      logic       sel;
      assign slot = evCfg[e*`BT_SLOT_W +: `BT_SLOT_W];
      assign sens = slot[`BT_SLOT_SENS_LO +: 2];
      assign sel  = syncB_r[e*4 + slot[1:0]];
      assign selLevel[e] = sel;
      always_comb begin
        case (burst_trigger_pkg::sens_mode_t'(sens))
          burst_trigger_pkg::SENS_LEVEL:
            evNow[e] = sel ^ slot[`BT_SLOT_POL];
          burst_trigger_pkg::SENS_RISE:
            evNow[e] = sel && !selPrev_r[e];
          burst_trigger_pkg::SENS_FALL:
            evNow[e] = !sel && selPrev_r[e];
          burst_trigger_pkg::SENS_BOTH:
            evNow[e] = sel ^ selPrev_r[e];
          default:
            evNow[e] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selPrev_r      <= 10'h000;
      extEventActive <= 10'h000;
    end else begin
      selPrev_r      <= selLevel;
      extEventActive <= evNow;
    end
  end

  // ---------------------------------------------------------------
  // Period-after-event arming
  // ---------------------------------------------------------------
  // A new event in the period cycle re-arms, so none is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armEv6_r <= 1'b0;
      armEv7_r <= 1'b0;
    end else begin
      armEv6_r <= extEventActive[6] || (armEv6_r && !secPeriod[0]);
      armEv7_r <= extEventActive[7] || (armEv7_r && !secPeriod[3]);
    end
  end

  // ---------------------------------------------------------------
  // Trigger collection
  // ---------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 5; t++) begin : g_sec
      assign trigEvents[`BT_ST_SEC_BASE + 4*t + 0] = secReset[t];
      assign trigEvents[`BT_ST_SEC_BASE + 4*t + 1] = secRepetition[t];
      assign trigEvents[`BT_ST_SEC_BASE + 4*t + 2] = secCompare0[t];
      assign trigEvents[`BT_ST_SEC_BASE + 4*t + 3] = secCompare1[t];
    end
  endgenerate

  assign trigEvents[`BT_ST_SW]       = startSel_r[`BT_ST_SW];
  assign trigEvents[1]               = primaryReset;
  assign trigEvents[2]               = primaryRepetition;
  assign trigEvents[6:3]             = primaryCompare;
  assign trigEvents[`BT_ST_SEC0_EV6] = armEv6_r && secPeriod[0];
  assign trigEvents[`BT_ST_SEC3_EV7] = armEv7_r && secPeriod[3];
  assign trigEvents[`BT_ST_EV6]      = extEventActive[6];
  assign trigEvents[`BT_ST_EV7]      = extEventActive[7];
  assign trigEvents[`BT_ST_INT]      = basicTimerTriggerOut;

  // Software bit is itself the enable, so it stands in both terms
  assign anyTrigger = |(trigEvents & startSel_r);
  // A trigger during a burst is dropped; restart needs the end first
  assign takeStart  = enable && anyTrigger && !stopWrite
                      && (state_r == burst_trigger_pkg::BURST_OFF);

  // ---------------------------------------------------------------
  // Burst counter clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= 15'h0000;
    end else begin
      presc_r <= presc_r + 15'h0001;
    end
  end

  always_comb begin
    logic [3:0] src;
    logic [3:0] psc;
    src = ctl_r[`BT_CTL_CLKS_LO +: 4];
    psc = ctl_r[`BT_CTL_PSC_LO +: 4];
    case (src)
      4'h0:    tick = primaryReset;
      4'h1:    tick = secReset[0];
      4'h2:    tick = secReset[1];
      4'h3:    tick = secReset[2];
      4'h4:    tick = secReset[3];
      4'h5:    tick = secReset[4];
      4'h6:    tick = burstClockIn[0];
      4'h7:    tick = burstClockIn[1];
      4'h8:    tick = burstClockIn[2];
      4'h9:    tick = burstClockIn[3];
      `BT_CLKS_PRESC:
        tick = ((presc_r & prescMask(psc)) == prescMask(psc));
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Burst state and counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= burst_trigger_pkg::BURST_OFF;
      count_r <= '0;
    end else if (stopWrite || !enable) begin
      state_r <= burst_trigger_pkg::BURST_OFF;
      count_r <= '0;
    end else if (takeStart) begin
      count_r <= '0;
      state_r <= (cmpPre_r == '0) ? burst_trigger_pkg::BURST_RUN
                                  : burst_trigger_pkg::BURST_IDLE;
    end else if (state_r != burst_trigger_pkg::BURST_OFF && tick) begin
      if (count_r == reloadAct_r) begin
        if (ctl_r[`BT_CTL_CONT]) begin
          count_r <= '0;
          // Active compare takes the preload at this edge, so judge on it
          state_r <= (cmpPre_r == '0) ? burst_trigger_pkg::BURST_RUN
                                      : burst_trigger_pkg::BURST_IDLE;
        end else begin
          state_r <= burst_trigger_pkg::BURST_OFF;
        end
      end else begin
        count_r <= count_r + 1'b1;
        state_r <= (count_r + 1'b1 >= cmpAct_r)
                   ? burst_trigger_pkg::BURST_RUN
                   : burst_trigger_pkg::BURST_IDLE;
      end
    end
  end

  // Active copies follow preload directly unless shadowing is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpAct_r    <= '0;
      reloadAct_r <= '0;
    end else if (!ctl_r[`BT_CTL_SHADOW] || takeStart
                 || (tick && count_r == reloadAct_r
                     && state_r != burst_trigger_pkg::BURST_OFF)) begin
      cmpAct_r    <= cmpPre_r;
      reloadAct_r <= reloadPre_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burstStart   <= 1'b0;
      burstRunning <= 1'b0;
      burstIdle    <= 1'b0;
      burstCount   <= '0;
    end else begin
      burstStart   <= takeStart;
      burstRunning <= (state_r != burst_trigger_pkg::BURST_OFF);
      burstIdle    <= (state_r == burst_trigger_pkg::BURST_IDLE);
      burstCount   <= count_r;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= `BT_RST_WORD;
    end else if (wrCtl) begin
      ctl_r <= regWdata & `BT_CTL_MASK;
    end
  end

  // Software start: a fresh write wins over the hardware clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startSel_r <= `BT_RST_WORD;
    end else if (wrStart) begin
      startSel_r[31:1] <= regWdata[31:1];
      startSel_r[`BT_ST_SW] <= regWdata[`BT_ST_SW] && enable;
    end else if (enable) begin
      startSel_r[`BT_ST_SW] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpPre_r    <= '0;
      reloadPre_r <= '0;
      evLo_r      <= `BT_RST_WORD;
      evHi_r      <= `BT_RST_WORD;
    end else if (regWrite) begin
      if (hit(regAddr, `BT_OFF_CMP)) begin
        cmpPre_r <= regWdata[CNT_W-1:0];
      end
      if (hit(regAddr, `BT_OFF_RELOAD)) begin
        reloadPre_r <= regWdata[CNT_W-1:0];
      end
      if (hit(regAddr, `BT_OFF_EVLO)) begin
        evLo_r <= regWdata & `BT_EV_MASK;
      end
      if (hit(regAddr, `BT_OFF_EVHI)) begin
        evHi_r <= regWdata & `BT_EV_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        `BT_OFF_CTL:    regRdata <= ctl_r | {
                          (state_r != burst_trigger_pkg::BURST_OFF),
                          31'h0000_0000};
        `BT_OFF_START:  regRdata <= startSel_r;
        `BT_OFF_CMP:    regRdata <= 32'(cmpPre_r);
        `BT_OFF_RELOAD: regRdata <= 32'(reloadPre_r);
        `BT_OFF_EVLO:   regRdata <= evLo_r;
        `BT_OFF_EVHI:   regRdata <= evHi_r;
        default:        regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : burst_trigger_and_ext_event_cfg

/* tb/burst_trigger_and_ext_event_cfg_assertions.sv */
// Port-level checks for the burst trigger block
`timescale 1ns/1ps
module burst_trigger_and_ext_event_cfg_assertions #(
  parameter int CNT_W = 16
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [7:0]       regAddr,
  input wire logic [31:0]      regWdata,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [31:0]      regRdata,
  input wire logic             burstStart,
  input wire logic             burstRunning,
  input wire logic             burstIdle,
  input wire logic [CNT_W-1:0] burstCount
);
  // ------
  // Sequences
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence readOf(logic [7:0] a);
    regRead && regAddr == a;
  endsequence

  // Only a clear enable stops for sure; bit 31 alone may restart at once
  sequence stopWrite;
    regWrite && regAddr == 8'h20 && !regWdata[0];
  endsequence

  // ------
  // Assertions
  // ------
  AST_RD_QUIET: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data not zero outside read slot");
  AST_CMP_UPPER: assert property (
    readOf(8'h28) |=> regRdata[31:16] == 16'h0)
    else $error("compare upper half not zero");
  AST_RELOAD_UPPER: assert property (
    readOf(8'h2C) |=> regRdata[31:16] == 16'h0)
    else $error("reload upper half not zero");
  AST_EVT_RSVD: assert property (
    (readOf(8'h30) or readOf(8'h34))
    |=> (regRdata & ~32'h1F7DF7DF) == 32'h0)
    else $error("event config reserved bit set");
  AST_START_PULSE: assert property (burstStart |=> !burstStart)
    else $error("start longer than one cycle");
  AST_START_RUNS: assert property (
    burstStart |-> ##[0:1] burstRunning)
    else $error("start without running");
  AST_START_ZERO: assert property (
    burstStart |-> ##[0:1] burstCount == '0)
    else $error("counter not cleared at start");
  AST_STOP: assert property (stopWrite |-> ##2 !burstRunning)
    else $error("burst not stopped by disable");
  AST_IDLE_IN_BURST: assert property (burstIdle |-> burstRunning)
    else $error("idle phase outside burst");
  AST_COUNT_STEP: assert property (
    burstRunning && $past(burstRunning)
    |-> burstCount == $past(burstCount) || burstCount == '0
        || burstCount == $past(burstCount) + 1'b1)
    else $error("counter jumped");
endmodule : burst_trigger_and_ext_event_cfg_assertions

/* tb/timer_units_model.sv */
// Master and slave timer units issuing one-cycle event pulses
`timescale 1ns/1ps
module timer_units_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] fire,
  input wire logic [4:0]  perFire,
  output logic            primaryReset,
  output logic            primaryRepetition,
  output logic [3:0]      primaryCompare,
  output logic [4:0]      secReset,
  output logic [4:0]      secRepetition,
  output logic [4:0]      secCompare0,
  output logic [4:0]      secCompare1,
  output logic [4:0]      secPeriod,
  output logic            basicTimerTriggerOut
);
  // ------
  // Event pulses
  // ------
  // Commands use start-select bit positions so a scenario names one bit
  logic [31:0] ev_r;
  logic [4:0]  per_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_r  <= 32'h0;
      per_r <= 5'h0;
    end else begin
      ev_r  <= fire;
      per_r <= perFire;
    end
  end

  assign primaryReset         = ev_r[1];
  assign primaryRepetition    = ev_r[2];
  assign primaryCompare       = ev_r[6:3];
  assign secPeriod            = per_r;
  assign basicTimerTriggerOut = ev_r[31];
  for (genvar t = 0; t < 5; t++) begin : g_sec
    assign secReset[t]      = ev_r[7+4*t];
    assign secRepetition[t] = ev_r[8+4*t];
    assign secCompare0[t]   = ev_r[9+4*t];
    assign secCompare1[t]   = ev_r[10+4*t];
  end
endmodule : timer_units_model

/* tb/burst_trigger_and_ext_event_cfg_bench.sv */
// Self-checking bench for the burst trigger block
`timescale 1ns/1ps
module burst_trigger_and_ext_event_cfg_bench;
  // ------
  // Signals
  // ------
  localparam int CNT_W = 16;
  logic             clk, rst_n, regWrite, regRead;
  logic [7:0]       regAddr;
  logic [31:0]      regWdata, regRdata, fire;
  logic [4:0]       perFire, secReset, secRepetition, secCompare0;
  logic [4:0]       secCompare1, secPeriod;
  logic             primaryReset, primaryRepetition, basicTimerTriggerOut;
  logic [3:0]       primaryCompare;
  logic [39:0]      extSourceIn;
  logic [9:0]       extEventActive;
  logic             burstStart, burstRunning, burstIdle;
  logic [CNT_W-1:0] burstCount;
  int               nErrors, checks, st, idl, run;

  burst_trigger_and_ext_event_cfg #(.CNT_W(CNT_W)) dut (
    .clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .primaryReset, .primaryRepetition, .primaryCompare, .secReset,
    .secRepetition, .secCompare0, .secCompare1, .secPeriod,
    .basicTimerTriggerOut, .burstClockIn(4'h0), .extSourceIn,
    .extEventActive, .burstStart, .burstRunning, .burstIdle, .burstCount);

  timer_units_model u_units (
    .clk, .rst_n, .fire, .perFire, .primaryReset, .primaryRepetition,
    .primaryCompare, .secReset, .secRepetition, .secCompare0,
    .secCompare1, .secPeriod, .basicTimerTriggerOut);

  // ------
  // Helpers
  // ------
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Whole words only; strobe drops at the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(n, regRdata, e);
  endtask : rd

  task automatic pulse(input logic [31:0] f, input logic [4:0] p);
    @(posedge clk);
    fire    <= f;
    perFire <= p;
    @(posedge clk);
    fire    <= 32'h0;
    perFire <= 5'h0;
  endtask : pulse

  task automatic pin(input int b, input logic v);
    @(posedge clk);
    extSourceIn[b] <= v;
  endtask : pin

  task automatic measure(input int n);
    st = 0;
    idl = 0;
    run = 0;
    repeat (n) begin
      @(negedge clk);
      if (burstStart === 1'b1) st++;
      if (burstIdle === 1'b1) idl++;
      if (burstRunning === 1'b1 && burstIdle === 1'b0) run++;
    end
  endtask : measure

  task automatic wrapUp();
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrapUp

  // ------
  // Scenarios
  // ------
  task automatic regsCheck();
    logic [7:0]  a [5] = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h40};
    logic [31:0] m [5] = '{32'h0000FFFF, 32'h0000FFFF, 32'h1F7DF7DF,
                           32'h1F7DF7DF, 32'h0};
    for (int i = 0; i < 5; i++) rd(a[i], 32'h0, "reset value");
    for (int i = 0; i < 5; i++) begin
      wr(a[i], 32'hFFFFFFFF);
      rd(a[i], m[i], "writable bits");
      wr(a[i], 32'h0);
    end
  endtask : regsCheck

  task automatic softStart();
    wr(8'h28, 32'h2);
    wr(8'h2C, 32'h5);
    wr(8'h24, 32'h1);
    measure(6);
    chk("start while off", st, 0);
    rd(8'h24, 32'h0, "soft bit while off");
    wr(8'h20, 32'h29);
    wr(8'h24, 32'h1);
    measure(20);
    chk("soft starts", st, 1);
    chk("idle cycles", idl, 2);
    chk("run cycles", run, 4);
    chk("final count", burstCount, 32'h5);
    rd(8'h24, 32'h0, "soft bit cleared");
  endtask : softStart

  // Preload lands only at start or rollover once shadowing is on
  task automatic shadowLoad();
    wr(8'h20, 32'h429);
    wr(8'h24, 32'h1);
    wr(8'h28, 32'h4);
    measure(16);
    chk("shadow idle", idl, 2);
    chk("shadow run", run, 4);
    wr(8'h24, 32'h1);
    measure(16);
    chk("reloaded idle", idl, 4);
    chk("reloaded run", run, 2);
    wr(8'h28, 32'h2);
  endtask : shadowLoad

  // Divide by two: the counter moves on every second clock only
  task automatic prescale();
    logic [CNT_W-1:0] prev;
    int               n;
    wr(8'h20, 32'h6B);
    wr(8'h24, 32'h1);
    repeat (4) @(negedge clk);
    prev = burstCount;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (burstCount !== prev) n++;
      prev = burstCount;
    end
    chk("prescaled ticks", n, 10);
    wr(8'h20, 32'h0);
  endtask : prescale

  task automatic contStop();
    wr(8'h20, 32'h2B);
    wr(8'h24, 32'h2);
    pulse(32'h2, 5'h0);
    measure(10);
    chk("cont start", st, 1);
    pulse(32'h2, 5'h0);
    measure(30);
    chk("retrigger dropped", st, 0);
    chk("still running", 32'(burstRunning), 32'h1);
    rd(8'h20, 32'h8000002B, "running flag");
    wr(8'h20, 32'h0);
    measure(3);
    chk("stopped", 32'(burstRunning), 32'h0);
    rd(8'h20, 32'h0, "flag cleared");
  endtask : contStop

  task automatic triggers();
    wr(8'h20, 32'h29);
    for (int b = 1; b < 32; b++) begin
      if (b < 27 || b == 31) begin
        wr(8'h24, 32'h1 << b);
        pulse(~(32'h1 << b), 5'h1F);
        measure(6);
        chk("unselected event", st, 0);
        pulse(32'h1 << b, 5'h0);
        measure(16);
        chk("selected event", st, 1);
      end
    end
  endtask : triggers

  task automatic arming();
    for (int i = 0; i < 2; i++) begin
      wr(8'h24, 32'h1 << (27 + i));
      pulse(32'h0, 5'h1 << (3 * i));
      measure(8);
      chk("period unarmed", st, 0);
      pin(24 + 4 * i, 1'b1);
      measure(6);
      pulse(32'h0, 5'h1 << (3 * i));
      measure(16);
      chk("period armed", st, 1);
      pin(24 + 4 * i, 1'b0);
      measure(16);
      // A held level would restart after each burst, so pulse one clock
      wr(8'h24, 32'h1 << (29 + i));
      pin(24 + 4 * i, 1'b1);
      pin(24 + 4 * i, 1'b0);
      measure(16);
      chk("event start", st, 1);
    end
  endtask : arming

  // Level high, level low, rise, fall, both; edge modes set polarity 1
  task automatic conditioning();
    int         e, s, m, n;
    logic [5:0] slot;
    int         expCnt [5] = '{5, 10, 1, 1, 2};
    wr(8'h24, 32'h0);
    for (int k = 0; k < 40; k++) begin
      e = (k < 20) ? 0 : 9;
      s = (k / 5) % 4;
      m = k % 5;
      slot = (m < 2) ? {3'h0, m[0], 2'h0} : {1'b0, 2'(m - 1), 3'h4};
      slot[1:0] = 2'(s);
      wr((e < 5) ? 8'h30 : 8'h34, 32'(slot) << (6 * (e % 5)));
      repeat (4) @(posedge clk);
      n = 0;
      for (int c = 0; c < 15; c++) begin
        @(posedge clk);
        extSourceIn[e * 4 + s] <= (c >= 5 && c < 10);
        @(negedge clk);
        if (extEventActive[e] === 1'b1) n++;
      end
      chk("event conditioning", n, expCnt[m]);
    end
  endtask : conditioning

  // ------
  // Main sequence
  // ------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst_n       = 1'b0;
    regWrite    = 1'b0;
    regRead     = 1'b0;
    regAddr     = 8'h0;
    regWdata    = 32'h0;
    fire        = 32'h0;
    perFire     = 5'h0;
    extSourceIn = 40'h0;
    nErrors     = 0;
    checks      = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    regsCheck();
    softStart();
    shadowLoad();
    contStop();
    prescale();
    triggers();
    arming();
    conditioning();
    wrapUp();
  end
endmodule : burst_trigger_and_ext_event_cfg_bench

bind burst_trigger_and_ext_event_cfg
  burst_trigger_and_ext_event_cfg_assertions #(.CNT_W(CNT_W)) u_chk (
    .clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .burstStart, .burstRunning, .burstIdle, .burstCount);
